// *** dv/tb.sv ***
/*
 * Self-checking bench for the oscillator trim and slow oscillator capture block.
 * Assumes the design files are compiled first and osc_defs.svh is on the include path.
 */
`timescale 1ns/10ps
`default_nettype none
`include "osc_defs.svh"

module tb;
    logic              clock;
    logic              srst;
    logic              sfr_wr;
    logic              sfr_rd;
    logic              cr_en;
    logic              raw;
    logic              m2;
    logic              m3;
    logic [7:0]        sfr_addr;
    logic [7:0]        sfr_wdata;
    logic [7:0]        sfr_rdata;
    logic [7:0]        hf_ctl;
    logic [7:0]        d;
    logic [7:0]        q;
    logic [4:0]        factory_trim;
    logic [4:0]        recovery_trim;
    logic [4:0]        trim_code;
    logic [3:0]        adj;
    logic [3:0]        adj_o;
    logic [1:0]        div;
    logic [1:0]        div_o;
    logic              hf_en;
    logic              hf_rdy;
    logic              lf_en;
    logic              lf_clk;
    logic              lfo_prev;
    logic [15:0]       c2_prev;
    logic [15:0]       c3_prev;
    logic [15:0]       c3_cap;
    logic              win;
    osc_pkg::count_s   t2_cnt;
    osc_pkg::count_s   t3_cnt;
    osc_pkg::capture_s t2_rl;
    osc_pkg::capture_s t3_rl;
    int                error_cnt;
    int                n_compared;
    int                n_rise;
    int                n_r3;
    int                n_f2;

    osc_trim_lf_capture i_osc_trim_lf_capture (
        .clock(clock), .srst(srst), .sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata),
        .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_rdata(sfr_rdata),
        .factory_trim(factory_trim), .clock_recovery_en(cr_en),
        .recovery_trim(recovery_trim), .lf_osc_raw(raw),
        .timer2_lf_capture_mode(m2), .timer3_lf_capture_mode(m3),
        .timer2_count(t2_cnt), .timer3_count(t3_cnt),
        .timer2_reload(t2_rl), .timer3_reload(t3_rl), .hf_trim_code(trim_code),
        .hf_osc_enable(hf_en), .hf_osc_ready(hf_rdy), .hf_osc_control(hf_ctl),
        .lf_osc_enable(lf_en), .lf_divider_select(div_o),
        .lf_frequency_adjust(adj_o), .lf_clk_out(lf_clk)
    );

    initial begin
        clock = 1'b0;
        forever #25 clock = ~clock;
    end

    ////////////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string msg);
        n_compared++;
        if (got !== exp) begin
            error_cnt++;
            $display("[ERR] %0t %s got %h exp %h", $time, msg, got, exp);
        end
    endtask : chk

    // timer 3 steps down by 3 per cycle, one raw period is 20 cycles
    function automatic logic [15:0] exp_period(input logic [1:0] sel);
        return 16'h003C << sel;
    endfunction : exp_period

    // divided edges seen in a window of 16 raw periods
    function automatic logic [15:0] exp_edges(input logic [1:0] sel);
        return 16'h0010 >> sel;
    endfunction : exp_edges

    task automatic tick(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask : tick

    // one idle cycle after each access keeps strobes from being reassigned in one step
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        sfr_addr = a;
        sfr_wdata = v;
        sfr_wr = 1'b1;
        tick(1);
        sfr_wr = 1'b0;
        tick(1);
    endtask : wr

    task automatic rd(input logic [7:0] a, output logic [7:0] v);
        sfr_addr = a;
        sfr_rd = 1'b1;
        tick(1);
        sfr_rd = 1'b0;
        v = sfr_rdata;
        tick(1);
    endtask : rd

    task automatic pulses(input int n);
        repeat (n) begin
            raw = 1'b1;
            tick(10);
            raw = 1'b0;
            tick(10);
        end
    endtask : pulses

    task automatic test_done();
        $display("errors %0d compares %0d", error_cnt, n_compared);
        if (error_cnt == 0 && n_compared > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : test_done

    ////////////////////////////////////////////////////////////////////////////////
    // free-running timers and capture monitor
    always @(posedge clock) begin
        c2_prev <= t2_cnt;
        c3_prev <= t3_cnt;
        #1;
        t2_cnt <= t2_cnt + 16'h0001;
        t3_cnt <= t3_cnt - 16'h0003;
    end

    always @(negedge clock) begin
        if (srst === 1'b0) begin
            if (t3_rl.strobe === 1'b1) begin
                if (win && n_r3 > 0) begin
                    chk(16'(c3_cap - t3_rl.value), exp_period(div), "t3 period");
                end
                c3_cap = t3_rl.value;
                n_r3++;
                chk(t3_rl.value, c3_prev, "t3 value");
                chk(16'(lf_clk & ~lfo_prev), 16'h0001, "t3 edge");
            end
            if (t2_rl.strobe === 1'b1) begin
                n_f2++;
                chk(t2_rl.value, c2_prev, "t2 value");
                chk(16'(~lf_clk & lfo_prev), 16'h0001, "t2 edge");
            end
            if (lf_clk === 1'b1 && lfo_prev === 1'b0) begin
                n_rise++;
            end
            lfo_prev = lf_clk;
        end
    end

    initial begin
        tick(20000);
        error_cnt++;
        test_done();
    end

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        void'($urandom(32'h445393d4));
        {srst, sfr_wr, sfr_rd, cr_en, raw, m2, m3, lfo_prev} = 8'h80;
        {sfr_addr, sfr_wdata, error_cnt, n_compared, win} = '0;
        factory_trim = 5'($urandom);
        recovery_trim = 5'h00;
        t2_cnt = 16'($urandom);
        t3_cnt = 16'($urandom);
        tick(8);
        srst = 1'b0;
        chk(16'(trim_code), 16'(factory_trim), "trim reset");
        rd(`OSC_HF_TRIM_ADDR, q);
        chk(16'(q), {11'h000, factory_trim}, "trim reset read");
        rd(`OSC_LF_CTL_ADDR, q);
        chk(16'(q), 16'(`OSC_LF_CTL_RST), "lf ctl reset");
        rd(`OSC_HF_CTL_ADDR, q);
        chk(16'(q), 16'(`OSC_HF_CTL_RST), "hf ctl reset");
        for (int i = 0; i < 6; i++) begin
            d = (i == 0) ? 8'h00 : (i == 1) ? 8'hFF : 8'($urandom);
            wr(`OSC_HF_TRIM_ADDR, d);
            chk(16'(trim_code), 16'(d[4:0]), "trim code");
            rd(`OSC_HF_TRIM_ADDR, q);
            chk(16'(q), {11'h000, d[4:0]}, "trim read");
        end
        for (int i = 0; i < 2; i++) begin
            d = 8'($urandom);
            d[7] = (i == 0);
            wr(`OSC_HF_CTL_ADDR, d);
            chk(16'({hf_en, hf_rdy}), {14'h0000, d[7], d[7]}, "hf ready");
            chk(16'(hf_ctl), 16'(d), "hf ctl");
        end
        wr(8'hB1, 8'($urandom));
        rd(8'hB1, q);
        chk(16'(q), 16'h0000, "unmapped read");
        recovery_trim = 5'($urandom);
        cr_en = 1'b1;
        tick(2);
        wr(`OSC_HF_TRIM_ADDR, {3'h0, ~recovery_trim});
        chk(16'(trim_code), 16'(recovery_trim), "recovery trim");
        rd(`OSC_HF_TRIM_ADDR, q);
        chk(16'(q), 16'(recovery_trim), "recovery read");
        cr_en = 1'b0;
        wr(`OSC_HF_TRIM_ADDR, 8'h15);
        chk(16'(trim_code), 16'h0015, "trim after recovery");
        wr(`OSC_LF_CTL_ADDR, 8'h80);
        pulses(2);
        {n_r3, n_f2} = '0;
        pulses(4);
        tick(8);
        chk(16'(n_r3 + n_f2), 16'h0000, "capture with modes off");
        {m2, m3} = 2'b11;
        for (int k = 0; k < 4; k++) begin
            adj = 4'($urandom);
            div = 2'(k);
            d = {1'b1, 1'($urandom), adj, div};
            wr(`OSC_LF_CTL_ADDR, d);
            chk(16'({lf_en, adj_o, div_o}), 16'({1'b1, adj, div}), "lf fields");
            rd(`OSC_LF_CTL_ADDR, q);
            chk(16'(q), 16'(d), "lf ctl read");
            pulses(2);
            {n_rise, n_r3, n_f2} = '0;
            win = 1'b1;
            pulses(16);
            win = 1'b0;
            tick(8);
            chk(16'(n_rise), exp_edges(div), "divided edges");
            chk(16'(n_r3), exp_edges(div), "t3 captures");
            chk(16'(n_f2), exp_edges(div), "t2 captures");
        end
        test_done();
    end
endmodule : tb
`default_nettype wire

// *** src/lf_edge_sync.sv ***
/*
 * Three-stage synchroniser with edge pulses for the low-frequency oscillator
 * output.
 * Assumes the raw input is asynchronous to clock; srst is synchronous.
 */
`timescale 1ns/10ps
`default_nettype none

module lf_edge_sync (
    input  wire logic clock,
    input  wire logic srst,
    input  wire logic raw,
    output logic      level,
    output logic      rise,
    output logic      fall
);

    osc_pkg::sync_state_s q;
    osc_pkg::sync_state_s nxt_q;

    always_comb begin
        nxt_q       = q;
        nxt_q.s1    = raw;
        nxt_q.s2    = q.s1;
        nxt_q.s3    = q.s2;
        nxt_q.rise  = 1'b0;
        nxt_q.fall  = 1'b0;
        // a change counts once stages two and three agree
        if (q.s2 == q.s3 && q.s3 != q.level) begin
            nxt_q.level = q.s3;
            nxt_q.rise  = q.s3;
            nxt_q.fall  = ~q.s3;
        end
    end

    always_ff @(posedge clock) begin
        if (srst) begin
            q <= '0;
        end else begin
            q <= nxt_q;
        end
    end

    assign level = q.level;
    assign rise  = q.rise;
    assign fall  = q.fall;

    ////////////////////////////////////////////////////////////////////////////

    a_single_rise : assert property (@(posedge clock) disable iff (srst)
        rise |=> !rise && level)
        else $error("edge pulse lasted more than one cycle");

endmodule : lf_edge_sync

`default_nettype wire

// *** src/osc_defs.svh ***
/*
 * Register map, field positions and reset values of the oscillator trim and
 * low-frequency capture block.
 * Assumes an 8-bit special-function-register port with an 8-bit address.
 */
`ifndef OSC_DEFS_SVH
`define OSC_DEFS_SVH

// register addresses
`define OSC_LF_CTL_ADDR   8'h86
`define OSC_HF_CTL_ADDR   8'hB2
`define OSC_HF_TRIM_ADDR  8'hB3

// lf_osc_control fields
`define OSC_DIV_MSB       1
`define OSC_DIV_LSB       0
`define OSC_ADJ_MSB       5
`define OSC_ADJ_LSB       2
`define OSC_LF_EN_BIT     7

// hf_osc_control fields
`define OSC_HF_EN_BIT     7

// hf_osc_trim fields
`define OSC_TRIM_MSB      4
`define OSC_TRIM_PAD      3'h0

// reset values and the read data of idle or unmapped reads
`define OSC_LF_CTL_RST    8'h00
`define OSC_HF_CTL_RST    8'h00
`define OSC_READ_ZERO     8'h00

// divider select codes
`define OSC_DIV_BY1       2'h0
`define OSC_DIV_BY2       2'h1
`define OSC_DIV_BY4       2'h2
`define OSC_DIV_BY8       2'h3

// divider step
`define OSC_DIV_STEP      3'h1

`endif

// *** src/osc_pkg.sv ***
/*
 * Types shared by the oscillator trim and low-frequency capture block.
 * Assumes nothing of its surroundings.
 */
package osc_pkg;

    typedef struct packed {
        logic [7:0] high;
        logic [7:0] low;
    } count_s;

    typedef struct packed {
        logic   strobe;
        count_s value;
    } capture_s;

    typedef struct packed {
        logic s1;
        logic s2;
        logic s3;
        logic level;
        logic rise;
        logic fall;
    } sync_state_s;

    typedef struct packed {
        logic [7:0] lf_ctl;
        logic [7:0] hf_ctl;
        logic [4:0] hf_trim;
        logic [2:0] div_cnt;
        logic       lf_div;
        capture_s   cap2;
        capture_s   cap3;
        logic [7:0] rdata;
    } osc_state_s;

endpackage : osc_pkg

// *** src/osc_trim_lf_capture.sv ***
/*
 * Oscillator trim registers, low-frequency divider and timer capture of the
 * low-frequency oscillator output.
 * Assumes an 8-bit register port on clock, the analog oscillators outside,
 * and timer counts supplied on the same clock.
 */
// Overview of operation
// - five low trim bits set fast oscillator period; zero code is fastest.
// - all-ones trim code is slowest; codes in between are ordered monotonically.
// - trim register loads a per-part factory value at reset for 12 MHz.
// - trim contents follow recovery_trim while clock recovery is enabled.
// - slow internal oscillator runs undivided at about 80 kHz.
// - divider field divides the slow oscillator output by 1, 2, 4 or 8.
// - bits 5 to 2 of the slow control register adjust its frequency.
// - timer 2 capture mode captures on each falling edge of slow output.
// - timer 3 capture mode captures on each rising edge of slow output.
// - a capture copies the timer count into its reload high and low.
// - fast oscillator is usable right after the enabling write, no wait.
`timescale 1ns/10ps
`default_nettype none
`include "osc_defs.svh"

module osc_trim_lf_capture (
    input  wire logic              clock,
    input  wire logic              srst,
    input  wire logic [7:0]        sfr_addr,
    input  wire logic [7:0]        sfr_wdata,
    input  wire logic              sfr_wr,
    input  wire logic              sfr_rd,
    output logic      [7:0]        sfr_rdata,
    input  wire logic [4:0]        factory_trim,
    input  wire logic              clock_recovery_en,
    input  wire logic [4:0]        recovery_trim,
    input  wire logic              lf_osc_raw,
    input  wire logic              timer2_lf_capture_mode,
    input  wire logic              timer3_lf_capture_mode,
    input  wire osc_pkg::count_s   timer2_count,
    input  wire osc_pkg::count_s   timer3_count,
    output osc_pkg::capture_s      timer2_reload,
    output osc_pkg::capture_s      timer3_reload,
    output logic      [4:0]        hf_trim_code,
    output logic                   hf_osc_enable,
    output logic                   hf_osc_ready,
    output logic      [7:0]        hf_osc_control,
    output logic                   lf_osc_enable,
    output logic      [1:0]        lf_divider_select,
    output logic      [3:0]        lf_frequency_adjust,
    output logic                   lf_clk_out
);

    osc_pkg::osc_state_s q;
    osc_pkg::osc_state_s nxt_q;
    logic                lf_level;
    logic                lf_rise;

    ////////////////////////////////////////////////////////////////////////////

    lf_edge_sync u_lf_sync (
        .clock (clock),
        .srst  (srst),
        .raw   (lf_osc_raw),
        .level (lf_level),
        .rise  (lf_rise),
        .fall  ()
    );

    ////////////////////////////////////////////////////////////////////////////

    always_comb begin
        logic       wr_lf;
        logic       wr_hf;
        logic       wr_trim;
        logic [2:0] cnt;
        logic       div_out;
        cnt     = q.div_cnt;
        div_out = 1'b0;
        wr_lf   = sfr_wr && sfr_addr == `OSC_LF_CTL_ADDR;
        wr_hf   = sfr_wr && sfr_addr == `OSC_HF_CTL_ADDR;
        wr_trim = sfr_wr && sfr_addr == `OSC_HF_TRIM_ADDR;
        nxt_q   = q;

        if (wr_lf) begin
            nxt_q.lf_ctl = sfr_wdata;
        end
        if (wr_hf) begin
            nxt_q.hf_ctl = sfr_wdata;
        end
        // recovery owns the trim while enabled, so writes then are lost
        if (clock_recovery_en) begin
            nxt_q.hf_trim = recovery_trim;
        end else if (wr_trim) begin
            nxt_q.hf_trim = sfr_wdata[`OSC_TRIM_MSB:0];
        end

        // divider counts rising edges of the synchronised oscillator
        if (lf_rise) begin
            cnt = q.div_cnt + `OSC_DIV_STEP;
        end
        nxt_q.div_cnt = cnt;
        unique case (q.lf_ctl[`OSC_DIV_MSB:`OSC_DIV_LSB])
            `OSC_DIV_BY1: div_out = lf_level;
            `OSC_DIV_BY2: div_out = cnt[0];
            `OSC_DIV_BY4: div_out = cnt[1];
            `OSC_DIV_BY8: div_out = cnt[2];
        endcase
        nxt_q.lf_div = div_out;

        // each edge of the divided output gives one capture pulse
        nxt_q.cap2.strobe = timer2_lf_capture_mode && q.lf_div && !div_out;
        nxt_q.cap3.strobe = timer3_lf_capture_mode && !q.lf_div && div_out;
        if (nxt_q.cap2.strobe) begin
            nxt_q.cap2.value = timer2_count;
        end
        if (nxt_q.cap3.strobe) begin
            nxt_q.cap3.value = timer3_count;
        end

        nxt_q.rdata = `OSC_READ_ZERO;
        if (sfr_rd) begin
            unique case (sfr_addr)
                `OSC_LF_CTL_ADDR:  nxt_q.rdata = q.lf_ctl;
                `OSC_HF_CTL_ADDR:  nxt_q.rdata = q.hf_ctl;
                `OSC_HF_TRIM_ADDR: nxt_q.rdata = {`OSC_TRIM_PAD, q.hf_trim};
                default:           nxt_q.rdata = `OSC_READ_ZERO;
            endcase
        end
    end

    always_ff @(posedge clock) begin
        if (srst) begin
            q         <= '0;
            q.lf_ctl  <= `OSC_LF_CTL_RST;
            q.hf_ctl  <= `OSC_HF_CTL_RST;
            q.hf_trim <= factory_trim;
        end else begin
            q <= nxt_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////////

    assign sfr_rdata           = q.rdata;
    assign timer2_reload       = q.cap2;
    assign timer3_reload       = q.cap3;
    assign hf_trim_code        = q.hf_trim;
    assign hf_osc_control      = q.hf_ctl;
    assign hf_osc_enable       = q.hf_ctl[`OSC_HF_EN_BIT];
    assign hf_osc_ready        = q.hf_ctl[`OSC_HF_EN_BIT];
    assign lf_osc_enable       = q.lf_ctl[`OSC_LF_EN_BIT];
    assign lf_divider_select   = q.lf_ctl[`OSC_DIV_MSB:`OSC_DIV_LSB];
    assign lf_frequency_adjust = q.lf_ctl[`OSC_ADJ_MSB:`OSC_ADJ_LSB];
    assign lf_clk_out          = q.lf_div;

    ////////////////////////////////////////////////////////////////////////////

    a_trim_write : assert property (@(posedge clock) disable iff (srst)
        sfr_wr && sfr_addr == `OSC_HF_TRIM_ADDR && !clock_recovery_en
        |=> hf_trim_code == $past(sfr_wdata[`OSC_TRIM_MSB:0])
            && sfr_rdata == `OSC_READ_ZERO)
        else $error("trim write not taken");

    a_trim_stable : assert property (@(posedge clock) disable iff (srst)
        $changed(hf_trim_code)
        |-> $past(clock_recovery_en)
            || $past(sfr_wr && sfr_addr == `OSC_HF_TRIM_ADDR))
        else $error("trim changed without cause");

    a_trim_factory : assert property (@(posedge clock)
        srst |=> hf_trim_code == $past(factory_trim))
        else $error("trim not loaded from factory value");

    a_trim_recovery : assert property (@(posedge clock) disable iff (srst)
        clock_recovery_en ##1 sfr_rd && sfr_addr == `OSC_HF_TRIM_ADDR
        |=> sfr_rdata == {`OSC_TRIM_PAD, $past(recovery_trim, 2)})
        else $error("trim does not follow recovery");

    a_div_by_one : assert property (@(posedge clock) disable iff (srst)
        lf_divider_select == `OSC_DIV_BY1 && $stable(lf_divider_select)
        |=> lf_clk_out == $past(lf_level))
        else $error("undivided output does not follow oscillator");

    a_div_by_two : assert property (@(posedge clock) disable iff (srst)
        lf_divider_select == `OSC_DIV_BY2 && lf_rise && !sfr_wr
        |=> lf_clk_out != $past(lf_clk_out))
        else $error("divide by two missed a toggle");

    a_adjust_field : assert property (@(posedge clock) disable iff (srst)
        sfr_wr && sfr_addr == `OSC_LF_CTL_ADDR
        |=> lf_frequency_adjust == $past(sfr_wdata[`OSC_ADJ_MSB:`OSC_ADJ_LSB])
            ##1 lf_frequency_adjust == $past(lf_frequency_adjust) || $past(sfr_wr))
        else $error("adjust field not stored");

    a_cap_falling : assert property (@(posedge clock) disable iff (srst)
        $fell(lf_clk_out) && $past(timer2_lf_capture_mode)
        |-> timer2_reload.strobe && timer2_reload.value == $past(timer2_count))
        else $error("timer 2 missed falling-edge capture");

    a_cap_rising : assert property (@(posedge clock) disable iff (srst)
        $rose(lf_clk_out) && $past(timer3_lf_capture_mode)
        |-> timer3_reload.strobe && timer3_reload.value == $past(timer3_count)
            ##1 !timer3_reload.strobe)
        else $error("timer 3 missed rising-edge capture");

    a_cap_hold : assert property (@(posedge clock) disable iff (srst)
        !timer2_reload.strobe |-> $stable(timer2_reload.value))
        else $error("reload value changed without capture");

    a_hf_ready : assert property (@(posedge clock) disable iff (srst)
        sfr_wr && sfr_addr == `OSC_HF_CTL_ADDR && sfr_wdata[`OSC_HF_EN_BIT]
        |=> hf_osc_ready && hf_osc_enable)
        else $error("fast oscillator not ready after enable");

    a_cap2_cause : assert property (@(posedge clock) disable iff (srst)
        timer2_reload.strobe
        |-> !lf_clk_out && $past(lf_clk_out) && $past(timer2_lf_capture_mode))
        else $error("timer 2 capture without falling edge");

    a_cap3_cause : assert property (@(posedge clock) disable iff (srst)
        timer3_reload.strobe
        |-> lf_clk_out && !$past(lf_clk_out) && $past(timer3_lf_capture_mode))
        else $error("timer 3 capture without rising edge");

    a_cap_hold3 : assert property (@(posedge clock) disable iff (srst)
        !timer3_reload.strobe |-> $stable(timer3_reload.value))
        else $error("timer 3 reload changed without capture");

endmodule : osc_trim_lf_capture

`default_nettype wire
